/* File: src/swprot_top.sv */
/*
  Multi-channel over-current / over-temperature protection sequencer with
  a small register port. One protection machine per channel.
  Assumes current and temperature comparators arrive as synchronous bits;
  channel control inputs are pins and are synchronised here.
*/
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "swprot_params.svh"

module swprot_top
  import swprot_pkg::*;
#(
  parameter swprot_pkg::swprot_cnt_t LIMIT_PULSE_CYC   = `SWP_CNT_W'(`SWP_LIMIT_PULSE_CYC),
  parameter swprot_pkg::swprot_cnt_t RETRY_DELAY_CYC   = `SWP_CNT_W'(`SWP_RETRY_DELAY_CYC),
  parameter swprot_pkg::swprot_cnt_t RETRY_PERIOD_CYC  = `SWP_CNT_W'(`SWP_RETRY_PERIOD_CYC),
  parameter swprot_pkg::swprot_cnt_t PROT_DURATION_CYC = `SWP_CNT_W'(`SWP_PROT_DURATION_CYC),
  parameter swprot_pkg::swprot_cnt_t PEAK_TEST_CYC     = `SWP_CNT_W'(`SWP_PEAK_TEST_CYC),
  parameter swprot_pkg::swprot_cnt_t PEAK_LIMIT_CYC    = `SWP_CNT_W'(`SWP_PEAK_LIMIT_CYC)
)
(
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic [31:0]                     reg_rdata,
  // channel pins and comparators
  input  wire swprot_pkg::swprot_chmask_t channel_control_input,
  input  wire swprot_pkg::swprot_chmask_t over_detect,
  input  wire swprot_pkg::swprot_chmask_t over_peak,
  input  wire swprot_pkg::swprot_chmask_t overtemp_hit,
  input  wire swprot_pkg::swprot_chmask_t temp_released,
  output swprot_pkg::swprot_chmask_t      channel_switch_output,
  output swprot_pkg::swprot_chmask_t      current_limit_active,
  output swprot_pkg::swprot_chmask_t      peak_limit_select,
  output logic                            clamp_low_select,
  output swprot_pkg::swprot_chmask_t      overcurrent_shutdown_flag,
  output swprot_pkg::swprot_chmask_t      overtemp_constraint_flag,
  output logic                            overtemp_all_shutdown_flag
);

  // ==========================================================
  // declarations
  logic           auto_clear_enable;
  swprot_chmask_t ctrl_meta;
  swprot_chmask_t ctrl_sync;
  swprot_chmask_t hot;
  logic           any_hot;
  logic           all_shut;
  logic           wr_status;
  swprot_chmask_t clear_oc;
  swprot_chmask_t clear_cns;
  logic           clear_all_sd;
  swprot_chmask_t go_shut;
  swprot_chmask_t go_retry;
  swprot_chmask_t episode;

  swprot_state_t  state      [`SWP_NUM_CH];
  swprot_state_t  next_state [`SWP_NUM_CH];
  swprot_cnt_t    step_cnt   [`SWP_NUM_CH];
  swprot_cnt_t    period_cnt [`SWP_NUM_CH];
  swprot_cnt_t    dur_cnt    [`SWP_NUM_CH];

  // ==========================================================
  // control pins cross in through two flops
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ctrl_meta <= '0;
      ctrl_sync <= '0;
    end
    else
    begin
      ctrl_meta <= channel_control_input;
      ctrl_sync <= ctrl_meta;
    end
  end

  // ==========================================================
  // register writes
  assign wr_status    = reg_write && (reg_addr == `SWP_ADDR_STATUS);
  assign clear_oc     = wr_status ? reg_wdata[`SWP_ST_OC_LSB +: `SWP_NUM_CH] : '0;
  assign clear_cns    = wr_status ? reg_wdata[`SWP_ST_CNS_LSB +: `SWP_NUM_CH] : '0;
  assign clear_all_sd = wr_status && reg_wdata[`SWP_ST_ALLSD_BIT];

  // auto clear resets to on
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      auto_clear_enable <= `SWP_CTRL_RESET;
    else if (reg_write && (reg_addr == `SWP_ADDR_CTRL))
      auto_clear_enable <= reg_wdata[`SWP_CTRL_AUTOCLR];
  end

  // ==========================================================
  // register reads, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (!reg_read)
      reg_rdata <= '0;
    else
    begin
      reg_rdata <= '0;
      unique case (reg_addr)
        `SWP_ADDR_CTRL:
          reg_rdata[`SWP_CTRL_AUTOCLR] <= auto_clear_enable;
        `SWP_ADDR_STATUS:
        begin
          reg_rdata[`SWP_ST_OC_LSB +: `SWP_NUM_CH]  <= overcurrent_shutdown_flag;
          reg_rdata[`SWP_ST_CNS_LSB +: `SWP_NUM_CH] <= overtemp_constraint_flag;
          reg_rdata[`SWP_ST_ALLSD_BIT]              <= overtemp_all_shutdown_flag;
        end
        `SWP_ADDR_STATE:
        begin
          reg_rdata[`SWP_SV_ON_LSB +: `SWP_NUM_CH]   <= channel_switch_output;
          reg_rdata[`SWP_SV_LIM_LSB +: `SWP_NUM_CH]  <= current_limit_active;
          reg_rdata[`SWP_SV_PEAK_LSB +: `SWP_NUM_CH] <= peak_limit_select;
          reg_rdata[`SWP_SV_CLAMP_BIT]               <= clamp_low_select;
          reg_rdata[`SWP_SV_HOT_BIT]                 <= any_hot;
          reg_rdata[`SWP_SV_ALLSD_BIT]               <= all_shut;
        end
        default:
          reg_rdata <= '0; // unmapped reads as zero
      endcase
    end
  end

  // ==========================================================
  // over-temperature supervision shared by all channels
  swprot_otemp u_otemp (
    .ref_clk                    (ref_clk),
    .resetn                     (resetn),
    .overtemp_hit               (overtemp_hit),
    .temp_released              (temp_released),
    .auto_clear_enable          (auto_clear_enable),
    .clear_cns                  (clear_cns),
    .clear_all_sd               (clear_all_sd),
    .hot                        (hot),
    .all_shut                   (all_shut),
    .clamp_low_select           (clamp_low_select),
    .overtemp_constraint_flag   (overtemp_constraint_flag),
    .overtemp_all_shutdown_flag (overtemp_all_shutdown_flag)
  );

  // one hot channel holds every channel back
  assign any_hot = |hot;

  // ==========================================================
  // per-channel protection machines
  genvar i;
  generate
    for (i = 0; i < `SWP_NUM_CH; i++)
    begin : g_ch

      // next state; comparator bits are used as-is, already synchronous
      always_comb
      begin
        next_state[i] = state[i];
        go_shut[i]    = 1'b0;
        go_retry[i]   = 1'b0;
        if (all_shut)
          next_state[i] = ST_OFF;
        else
        begin
          unique case (state[i])
            ST_OFF:
              if (ctrl_sync[i] && !any_hot)
                next_state[i] = ST_ON;
            ST_ON:
              if (!ctrl_sync[i])
                next_state[i] = ST_OFF;
              else if (over_detect[i])
                next_state[i] = ST_LIMIT;
            ST_LIMIT:
              if (!ctrl_sync[i])
                next_state[i] = ST_OFF;
              else if (!over_detect[i])
                next_state[i] = ST_ON;
              else if (dur_cnt[i] >= PROT_DURATION_CYC - 1'b1)
                next_state[i] = ST_PEAK;
              else if (step_cnt[i] >= LIMIT_PULSE_CYC - 1'b1)
              begin
                next_state[i] = ST_SHUT;
                go_shut[i]    = 1'b1;
              end
            ST_PEAK:
              if (!ctrl_sync[i])
                next_state[i] = ST_OFF;
              else if (!over_detect[i])
                next_state[i] = ST_ON;
              else if (!over_peak[i])
                next_state[i] = ST_INRUSH;
              else if (step_cnt[i] >= PEAK_TEST_CYC - 1'b1)
              begin
                next_state[i] = ST_SHUT;
                go_shut[i]    = 1'b1;
              end
            ST_INRUSH:
              if (!ctrl_sync[i])
                next_state[i] = ST_OFF;
              else if (!over_detect[i])
                next_state[i] = ST_ON;
              else if (step_cnt[i] >= PEAK_LIMIT_CYC - 1'b1)
              begin
                next_state[i] = ST_SHUT;
                go_shut[i]    = 1'b1;
              end
            ST_SHUT:
              // load is not looked at while shut
              if ((step_cnt[i] >= RETRY_DELAY_CYC - 1'b1) &&
                  (period_cnt[i] >= RETRY_PERIOD_CYC - 1'b1))
              begin
                if (!ctrl_sync[i])
                  next_state[i] = ST_OFF;
                else if (!any_hot)
                begin
                  next_state[i] = ST_ON;
                  go_retry[i]   = 1'b1;
                end
              end
            default:
              next_state[i] = ST_OFF;
          endcase
        end
      end

      // state and registered switch controls
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
        begin
          state[i]                 <= ST_OFF;
          channel_switch_output[i] <= 1'b0;
          current_limit_active[i]  <= 1'b0;
          peak_limit_select[i]     <= 1'b0;
        end
        else
        begin
          state[i]                 <= next_state[i];
          channel_switch_output[i] <= (next_state[i] != ST_OFF) && (next_state[i] != ST_SHUT);
          current_limit_active[i]  <= (next_state[i] == ST_LIMIT) || (next_state[i] == ST_PEAK) ||
                                      (next_state[i] == ST_INRUSH);
          peak_limit_select[i]     <= (next_state[i] == ST_PEAK) || (next_state[i] == ST_INRUSH);
        end
      end

      // time spent in the present state, saturating
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          step_cnt[i] <= '0;
        else if (next_state[i] != state[i])
          step_cnt[i] <= '0;
        else if (step_cnt[i] != '1)
          step_cnt[i] <= step_cnt[i] + 1'b1;
      end

      // retry period runs from each limiting attempt
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          period_cnt[i] <= '0;
        else if ((state[i] == ST_ON) && (next_state[i] == ST_LIMIT))
          period_cnt[i] <= '0;
        else if (period_cnt[i] != '1)
          period_cnt[i] <= period_cnt[i] + 1'b1;
      end

      // episode spans repeated attempts until the load recovers
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          episode[i] <= 1'b0;
        else if ((next_state[i] == ST_OFF) || ((state[i] == ST_ON) && !over_detect[i]))
          episode[i] <= 1'b0;
        else if (next_state[i] == ST_LIMIT)
          episode[i] <= 1'b1;
      end

      // protection duration, restarted after each failed peak test
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          dur_cnt[i] <= '0;
        else if (!episode[i] || ((state[i] != ST_LIMIT) && go_shut[i]))
          dur_cnt[i] <= '0;
        else if (dur_cnt[i] != '1)
          dur_cnt[i] <= dur_cnt[i] + 1'b1;
      end

      // shutdown flag: set wins over both clears
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          overcurrent_shutdown_flag[i] <= 1'b0;
        else if (go_shut[i])
          overcurrent_shutdown_flag[i] <= 1'b1;
        else if ((auto_clear_enable && go_retry[i]) || clear_oc[i])
          overcurrent_shutdown_flag[i] <= 1'b0;
      end

    end
  endgenerate

endmodule : swprot_top

/* File: src/swprot_params.svh */
/*
  Constants for the switch protection sequencer: channel count, register
  offsets, field positions, reset values and protection timing counts.
  Assumes a 50 MHz ref_clk; cycle counts are derived from the times below.
*/
`ifndef SWPROT_PARAMS_SVH
`define SWPROT_PARAMS_SVH

// ==========================================================
// structure
`define SWP_NUM_CH          4
`define SWP_CNT_W           24

// ==========================================================
// register map (byte addresses, one word each)
`define SWP_ADDR_CTRL       8'h00
`define SWP_ADDR_STATUS     8'h04
`define SWP_ADDR_STATE      8'h08
`define SWP_CTRL_AUTOCLR    0
`define SWP_CTRL_RESET      1'b1
`define SWP_ST_OC_LSB       0
`define SWP_ST_CNS_LSB      4
`define SWP_ST_ALLSD_BIT    8
`define SWP_SV_ON_LSB       0
`define SWP_SV_LIM_LSB      4
`define SWP_SV_PEAK_LSB     8
`define SWP_SV_CLAMP_BIT    12
`define SWP_SV_HOT_BIT      13
`define SWP_SV_ALLSD_BIT    14

// ==========================================================
// protection times in ns, clock period in ns
`define SWP_CLK_NS             20
`define SWP_LIMIT_PULSE_NS     100000
`define SWP_RETRY_DELAY_NS     8000000
`define SWP_RETRY_PERIOD_NS    10000000
`define SWP_PROT_DURATION_NS   50000000
`define SWP_PEAK_TEST_NS       200000
`define SWP_PEAK_LIMIT_NS      25000000

// longest times round down, least times round up
`define SWP_LIMIT_PULSE_CYC    (`SWP_LIMIT_PULSE_NS / `SWP_CLK_NS)
`define SWP_RETRY_DELAY_CYC    ((`SWP_RETRY_DELAY_NS + `SWP_CLK_NS - 1) / `SWP_CLK_NS)
`define SWP_RETRY_PERIOD_CYC   ((`SWP_RETRY_PERIOD_NS + `SWP_CLK_NS - 1) / `SWP_CLK_NS)
`define SWP_PROT_DURATION_CYC  (`SWP_PROT_DURATION_NS / `SWP_CLK_NS)
`define SWP_PEAK_TEST_CYC      (`SWP_PEAK_TEST_NS / `SWP_CLK_NS)
`define SWP_PEAK_LIMIT_CYC     (`SWP_PEAK_LIMIT_NS / `SWP_CLK_NS)

`endif

/* File: src/swprot_pkg.sv */
/*
  Types shared by the switch protection sequencer.
  Assumes swprot_params.svh is on the include path.
*/
`include "swprot_params.svh"

package swprot_pkg;

  // ==========================================================
  // per-channel protection states, gray along the usual path
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_ON     = 3'h1,
    ST_LIMIT  = 3'h3,
    ST_SHUT   = 3'h2,
    ST_PEAK   = 3'h6,
    ST_INRUSH = 3'h7
  } swprot_state_t;

  typedef logic [`SWP_NUM_CH-1:0] swprot_chmask_t;
  typedef logic [`SWP_CNT_W-1:0]  swprot_cnt_t;

endpackage : swprot_pkg

/* File: src/swprot_otemp.sv */
/*
  Over-temperature supervisor: per-channel hot state and constraint flags,
  the all-channel shutdown and the low clamp select.
  Assumes the temperature comparator bits are synchronous to ref_clk.
*/
`timescale 1ns/100ps
`include "swprot_params.svh"

module swprot_otemp
  import swprot_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire swprot_pkg::swprot_chmask_t overtemp_hit,
  input  wire swprot_pkg::swprot_chmask_t temp_released,
  input  wire logic                 auto_clear_enable,
  input  wire swprot_pkg::swprot_chmask_t clear_cns,
  input  wire logic                 clear_all_sd,
  output swprot_pkg::swprot_chmask_t      hot,
  output logic                      all_shut,
  output logic                      clamp_low_select,
  output swprot_pkg::swprot_chmask_t      overtemp_constraint_flag,
  output logic                      overtemp_all_shutdown_flag
);

  swprot_chmask_t next_hot;
  logic           next_all_shut;

  // ==========================================================
  // hysteresis per channel
  genvar i;
  generate
    for (i = 0; i < `SWP_NUM_CH; i++)
    begin : g_ch
      always_comb
      begin
        next_hot[i] = hot[i];
        if (overtemp_hit[i])
          next_hot[i] = 1'b1;
        else if (temp_released[i])
          next_hot[i] = 1'b0;
      end

      // hardware set wins over any clear
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
          overtemp_constraint_flag[i] <= 1'b0;
        else if (overtemp_hit[i])
          overtemp_constraint_flag[i] <= 1'b1;
        else if ((auto_clear_enable && temp_released[i]) || clear_cns[i])
          overtemp_constraint_flag[i] <= 1'b0;
      end
    end
  endgenerate

  // shutdown only when overtemp_hit is high on every channel in the same cycle, held until all release
  always_comb
  begin
    next_all_shut = all_shut;
    if (&overtemp_hit)
      next_all_shut = 1'b1;
    else if (&temp_released)
      next_all_shut = 1'b0;
  end

  // ==========================================================
  // state registers
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      hot              <= '0;
      all_shut         <= 1'b0;
      clamp_low_select <= 1'b0;
    end
    else
    begin
      hot              <= next_hot;
      all_shut         <= next_all_shut;
      clamp_low_select <= (|next_hot) | next_all_shut;
    end
  end

  // global flag, set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      overtemp_all_shutdown_flag <= 1'b0;
    else if (&overtemp_hit)
      overtemp_all_shutdown_flag <= 1'b1;
    else if ((auto_clear_enable && &temp_released) || clear_all_sd)
      overtemp_all_shutdown_flag <= 1'b0;
  end

endmodule : swprot_otemp

/* File: sim/swprot_sva.sv */
/*
  Checker for the switch protection sequencer: channel 0 limit and shutdown
  timing, turn-on blocking and the all-channel over-temperature behaviour.
  Assumes the bench keeps auto clear on whenever every channel is hot.
*/
`timescale 1ns/100ps

module swprot_sva
  import swprot_pkg::*;
#(
  parameter swprot_pkg::swprot_cnt_t LIMIT_PULSE_CYC = 5
)
(
  input wire logic                       ref_clk,
  input wire logic                       resetn,
  input wire swprot_pkg::swprot_chmask_t over_detect,
  input wire swprot_pkg::swprot_chmask_t overtemp_hit,
  input wire swprot_pkg::swprot_chmask_t channel_switch_output,
  input wire swprot_pkg::swprot_chmask_t current_limit_active,
  input wire swprot_pkg::swprot_chmask_t peak_limit_select,
  input wire logic                       clamp_low_select,
  input wire swprot_pkg::swprot_chmask_t overcurrent_shutdown_flag,
  input wire swprot_pkg::swprot_chmask_t overtemp_constraint_flag,
  input wire logic                       overtemp_all_shutdown_flag
);
  swprot_cnt_t lim_run;
  logic        any_hit;

  // ==========================================================
  // helpers
  assign any_hit = |overtemp_hit;
  // length of the current plain limit pulse; peak phases are not timed here
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !current_limit_active[0] || peak_limit_select[0])
      lim_run <= '0;
    else
      lim_run <= lim_run + 1'b1;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // over-current
  limit_len_a : assert property (
    current_limit_active[0] && !peak_limit_select[0] |-> lim_run < LIMIT_PULSE_CYC)
    else $error("limit pulse overran");
  shut_hold_a : assert property (
    $rose(overcurrent_shutdown_flag[0]) |-> !channel_switch_output[0] [*8])
    else $error("shut channel came back early");
  detect_need_a : assert property (
    channel_switch_output[0] && !current_limit_active[0] && !over_detect[0] |=> !current_limit_active[0])
    else $error("limit without over-current");
  limit_entry_a : assert property (
    channel_switch_output[0] && !current_limit_active[0] && over_detect[0]
    |=> current_limit_active[0] || !channel_switch_output[0])
    else $error("over-current not limited");
  limit_drop_a : assert property (
    current_limit_active[0] && !peak_limit_select[0] && !over_detect[0] |=> !current_limit_active[0])
    else $error("limit held after over-current gone");

  // ==========================================================
  // over-temperature
  hot_block_a : assert property (
    $rose(channel_switch_output[0]) |-> !$past(any_hit, 2))
    else $error("turn-on while hot");
  clamp_low_a : assert property (
    any_hit |-> ##2 clamp_low_select)
    else $error("clamp not lowered");
  cns_set_a : assert property (
    $rose(overtemp_hit[1]) |-> ##[1:2] overtemp_constraint_flag[1])
    else $error("constraint flag not set");
  all_shut_a : assert property (
    &overtemp_hit |-> ##[1:3] (channel_switch_output == '0 && overtemp_all_shutdown_flag && clamp_low_select))
    else $error("all-channel shutdown missing");
  all_hold_a : assert property (
    overtemp_all_shutdown_flag && $past(overtemp_all_shutdown_flag) |-> channel_switch_output == '0)
    else $error("output on during all-channel shutdown");
endmodule : swprot_sva

bind swprot_top swprot_sva #(.LIMIT_PULSE_CYC(LIMIT_PULSE_CYC)) chk_u (.ref_clk, .resetn, .over_detect,
  .overtemp_hit, .channel_switch_output, .current_limit_active, .peak_limit_select, .clamp_low_select,
  .overcurrent_shutdown_flag, .overtemp_constraint_flag, .overtemp_all_shutdown_flag);

/* File: sim/swprot_load.sv */
/*
  Load model on each channel output: 0 normal, 1 dead short, 2 lamp whose
  over-current ends after some on-time, 3 overload below the peak limit.
  Assumes load_mode changes right after a clock edge.
*/
`timescale 1ns/100ps
`include "swprot_params.svh"

module swprot_load
  import swprot_pkg::*;
#(
  parameter int INRUSH_CYC = 30
)
(
  input  wire logic                       ref_clk,
  input  wire logic [7:0]                 load_mode,
  input  wire swprot_pkg::swprot_chmask_t channel_switch_output,
  output swprot_pkg::swprot_chmask_t      over_detect,
  output swprot_pkg::swprot_chmask_t      over_peak
);
  int warm [`SWP_NUM_CH];

  // lamp filament heats only while current flows
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < `SWP_NUM_CH; i++)
      warm[i] <= (load_mode[2*i+:2] != 2'h2) ? 0 : warm[i] + int'(channel_switch_output[i]);
  end

  // no current while off, so both comparators read low then
  always_comb
  begin
    for (int i = 0; i < `SWP_NUM_CH; i++)
    begin
      over_detect[i] = channel_switch_output[i] && (load_mode[2*i] || (load_mode[2*i+:2] == 2'h2 &&
                       warm[i] < INRUSH_CYC));
      over_peak[i] = channel_switch_output[i] && load_mode[2*i+:2] == 2'h1;
    end
  end
endmodule : swprot_load

/* File: sim/tb_swprot_top.sv */
/*
  Self-checking bench for the switch protection sequencer with every protection
  time but the peak test shortened, a load model and directed plus random stimulus.
  Assumes the checker is bound into swprot_top.
*/
`timescale 1ns/100ps
`include "swprot_params.svh"

module tb_swprot_top;
  import swprot_pkg::*;
  logic           ref_clk, resetn, reg_write, reg_read, clamp_low_select, overtemp_all_shutdown_flag;
  logic [7:0]     reg_addr, load_mode;
  logic [31:0]    reg_wdata, reg_rdata, rd;
  swprot_chmask_t channel_control_input, over_detect, over_peak, overtemp_hit, temp_released;
  swprot_chmask_t channel_switch_output, current_limit_active, peak_limit_select;
  swprot_chmask_t overcurrent_shutdown_flag, overtemp_constraint_flag;
  int             mismatches, num_checks;
  swprot_top #(.LIMIT_PULSE_CYC(24'h5), .RETRY_DELAY_CYC(24'h8), .RETRY_PERIOD_CYC(24'hC),
    .PROT_DURATION_CYC(24'h28), .PEAK_LIMIT_CYC(24'h14)) dut_u (.ref_clk, .resetn,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .channel_control_input, .over_detect,
    .over_peak, .overtemp_hit, .temp_released, .channel_switch_output, .current_limit_active,
    .peak_limit_select, .clamp_low_select, .overcurrent_shutdown_flag, .overtemp_constraint_flag,
    .overtemp_all_shutdown_flag);
  swprot_load load_u (.ref_clk, .load_mode, .channel_switch_output, .over_detect, .over_peak);
  // ==========================================================
  // clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_rd

  // kind: 0 shutdown flag, 1 switch on, 2 peak limit, 3 limiting
  task automatic wait_on(input int kind, input int ch, input logic v, input int lim);
    logic [3:0] s;
    repeat (lim)
    begin
      @(posedge ref_clk);
      #1 s = {current_limit_active[ch], peak_limit_select[ch], channel_switch_output[ch],
              overcurrent_shutdown_flag[ch]};
      if (s[kind] === v)
        return;
    end
    chk($sformatf("wait kind %0d ch %0d", kind, ch), 32'(v), 32'(s[kind]));
    wrap_up();
  endtask : wait_on

  // ==========================================================
  // main sequence
  initial
  begin
    {resetn, reg_write, reg_read, reg_addr, reg_wdata, load_mode, overtemp_hit} = '0;
    channel_control_input = '0;
    temp_released = '1;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(94314));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    reg_rd(`SWP_ADDR_CTRL);
    chk("ctrl reset", 32'h1, rd);
    reg_wr(`SWP_ADDR_STATE, 32'hFFFF_FFFF);
    reg_rd(`SWP_ADDR_STATE);
    chk("state read only", 32'h0, rd);
    reg_rd(8'h3C);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    // short on channel 0: limit, shutdown, retry, then peak test
    channel_control_input <= 4'h1;
    wait_on(1, 0, 1'b1, 10);
    chk("no limit idle", 32'h0, current_limit_active);
    load_mode <= 8'h01;
    wait_on(3, 0, 1'b1, 3);
    wait_on(0, 0, 1'b1, 8);
    chk("off in shutdown", 32'h0, channel_switch_output);
    reg_rd(`SWP_ADDR_STATUS);
    chk("status oc", 32'h1 << `SWP_ST_OC_LSB, rd);
    wait_on(0, 0, 1'b0, 14);
    chk("retry on", 32'h1, channel_switch_output);
    wait_on(2, 0, 1'b1, 80);
    wait_on(0, 0, 1'b1, 10010);
    load_mode <= 8'h00;
    @(posedge ref_clk);
    #1 chk("stay shut", 32'h0, channel_switch_output);
    wait_on(1, 0, 1'b1, 14);
    repeat (5) @(posedge ref_clk);
    #1 chk("resumed", 32'h1, {current_limit_active, channel_switch_output});
    load_mode <= 8'h01;
    wait_on(3, 0, 1'b1, 3);
    load_mode <= 8'h00;
    repeat (2) @(posedge ref_clk);
    #1 chk("limit released", 32'h1, {current_limit_active, channel_switch_output});
    $display("test over-current done");
    // overload below peak on channel 1, then a lamp
    channel_control_input <= 4'h3;
    load_mode <= 8'h0C;
    wait_on(2, 1, 1'b1, 90);
    repeat (8) @(posedge ref_clk);
    #1 chk("inrush hold", 32'h1, 32'(peak_limit_select[1]));
    wait_on(0, 1, 1'b1, 25);
    load_mode <= 8'h08;
    repeat (300) @(posedge ref_clk);
    #1 chk("lamp lit", 32'h3, {current_limit_active, channel_switch_output});
    $display("test inrush done");
    // one hot channel constrains and blocks every channel
    channel_control_input <= 4'h0;
    load_mode <= 8'h00;
    repeat (4) @(posedge ref_clk);
    overtemp_hit <= 4'h4;
    temp_released <= 4'hB;
    repeat (3) @(posedge ref_clk);
    channel_control_input <= 4'h3;
    repeat (8) @(posedge ref_clk);
    chk("blocked", 32'h0, channel_switch_output);
    chk("cns flag", 32'h4, overtemp_constraint_flag);
    chk("clamp low", 32'h1, 32'(clamp_low_select));
    overtemp_hit <= 4'h0;
    repeat (4) @(posedge ref_clk);
    chk("held hot", 32'h0, channel_switch_output);
    temp_released <= 4'hF;
    repeat (6) @(posedge ref_clk);
    #1 chk("released", 32'h3, {overtemp_constraint_flag, channel_switch_output});
    $display("test constraint done");
    // every channel hot
    channel_control_input <= 4'hF;
    repeat (6) @(posedge ref_clk);
    overtemp_hit <= 4'hF;
    temp_released <= 4'h0;
    repeat (3) @(posedge ref_clk);
    #1 chk("all off", 32'h10, {overtemp_all_shutdown_flag, channel_switch_output});
    reg_rd(`SWP_ADDR_STATE);
    chk("state hot", 32'h0000_7000, rd);
    overtemp_hit <= 4'h0;
    temp_released <= 4'h7;
    repeat (6) @(posedge ref_clk);
    chk("one still hot", 32'h10, {overtemp_all_shutdown_flag, channel_switch_output});
    temp_released <= 4'hF;
    repeat (6) @(posedge ref_clk);
    #1 chk("all resume", 32'h0F, {overtemp_all_shutdown_flag, channel_switch_output});
    $display("test all-shutdown done");
    // sticky flag with auto clear off, cleared by write
    reg_wr(`SWP_ADDR_CTRL, 32'h0);
    load_mode <= 8'h10;
    wait_on(0, 2, 1'b1, 20);
    load_mode <= 8'h00;
    repeat (40) @(posedge ref_clk);
    chk("sticky", 32'h1, 32'(overcurrent_shutdown_flag[2]));
    reg_wr(`SWP_ADDR_STATUS, 32'h4);
    reg_rd(`SWP_ADDR_STATUS);
    chk("cleared", 32'h0, rd);
    reg_wr(`SWP_ADDR_CTRL, 32'h1);
    $display("test auto clear done");
    // random control and loads, judged by the checker
    repeat (40)
    begin
      @(posedge ref_clk);
      channel_control_input <= 4'($urandom);
      load_mode <= 8'($urandom);
      repeat (10) @(posedge ref_clk);
    end
    $display("test random done");
    wrap_up();
  end
endmodule : tb_swprot_top
